// ==== logic/bcm_top.sv ====
// Notes on behaviour
// R1 - three address channels, first also compares data
// R2 - no matches in or from background debug
// R3 - direction enable, select 0 write, 1 read
// R4 - size on first two: 0 word, 1 byte
// R5 - tag mode: match at execution, qualifiers ignored
// R6 - forced mode: match on the address bus cycle
// R7 - software loads n-1 for odd opcode n
// R8 - each match judged only in its own cycle
// R9 - match outputs map to channels, range shares
// R10 - exact address equality in single mode
// R11 - third channel: address and direction only
// R12 - lower address byte meets high stored byte
// R13 - equality polarity: masked bits all equal
// R14 - difference polarity: some masked bit differs
// R15 - range uses first channel qualifiers, tag, break
// R16 - software sets or clears both compare enables
// R17 - tagged ranges resolve to word granularity
// R18 - inside range needs both bounds same cycle
// R19 - outside range needs either bound alone
// R20 - software picks full-space limit for outside
// R21 - final-state channel first, then lower number
// R22 - one-cycle pulse per matching cycle or hit
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
module bcm_top
  import bcm_pkg::*;
#(
  parameter int AW = CMP_ADDR_W,
  parameter int DW = CMP_DATA_W
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // axi4-lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // axi4-lite read
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [AXI_DW-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  // observed processor bus
  input  wire logic              bus_valid_i,
  input  wire logic [AW-1:0]     bus_addr_i,
  input  wire logic [DW-1:0]     bus_data_i,
  input  wire logic              bus_rw_i,
  input  wire logic              bus_word_i,
  input  wire logic              bus_fetch_i,
  // background debug state
  input  wire logic              background_debug_mode_i,
  input  wire logic              background_debug_access_i,
  // opcode tagging with the core
  output logic [CHAN_N-1:0]      tag_attach_o,
  input  wire logic [CHAN_N-1:0] tag_hit_i,
  // sequencer side
  input  wire logic [CHAN_N-1:0] final_state_chan_i,
  output logic [CHAN_N-1:0]      match_o,
  output logic [CHAN_N-1:0]      breakpoint_o
);

  // configuration and status registers
  logic [CTL_W-1:0]  ctl_reg [CHAN_N];
  logic [AW-1:0]     addr_reg [CHAN_N];
  logic [DW-1:0]     data_reg;
  logic [DW-1:0]     mask_reg;
  logic [RNG_W-1:0]  range_reg;
  logic [CHAN_N-1:0] last_reg;
  logic [CNT_W-1:0]  count_reg;

  // bus slave state
  logic              aw_held_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic              w_held_reg;
  logic [AXI_DW-1:0] wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [AXI_DW-1:0] rdata_reg;
  logic [1:0]        rresp_reg;

  // comparison results and per-channel control bits
  logic              bus_ok;
  logic              range_on;
  logic              word_gran;
  logic [CHAN_N-1:0] eq;
  logic [CHAN_N-1:0] ge;
  logic [CHAN_N-1:0] le;
  logic [CHAN_N-1:0] dir_ok;
  logic [CHAN_N-1:0] size_ok;
  logic              data_ok;
  logic              range_cond;
  logic [CHAN_N-1:0] forced_hit;
  logic [CHAN_N-1:0] attach;
  logic [CHAN_N-1:0] tagged_hit;
  logic [CHAN_N-1:0] raw_match;
  logic [CHAN_N-1:0] winner;
  logic [CHAN_N-1:0] ctl_en;
  logic [CHAN_N-1:0] ctl_tag;
  logic [CHAN_N-1:0] ctl_brk;

  logic              do_write;
  logic [AXI_DW-1:0] rd_word;
  logic              rd_hit;
  logic              wr_hit;

  // merge a write into an old word under byte strobes
  function automatic logic [AXI_DW-1:0] strb_merge(input logic [AXI_DW-1:0] old_w,
                                                   input logic [AXI_DW-1:0] new_w,
                                                   input logic [3:0]        strb);
    logic [AXI_DW-1:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // lowest set bit as one-hot
  function automatic logic [CHAN_N-1:0] lowest_one(input logic [CHAN_N-1:0] v);
    logic [CHAN_N-1:0] res;
    res = '0;
    for (int i = CHAN_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        res    = '0;
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction : lowest_one

  // per-channel control bits in vector form
  always_comb begin
    for (int i = 0; i < CHAN_N; i++) begin
      ctl_en[i]  = ctl_reg[i][CTL_EN];
      ctl_tag[i] = ctl_reg[i][CTL_TAG];
      ctl_brk[i] = ctl_reg[i][CTL_BRK];
    end
  end

  // ---------------- register bus ----------------

  // address and data accepted independently, one write in flight
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign do_write        = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;

  // holding registers for the write halves
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_i;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // decode of the held write address; status is read-only but answers okay
  always_comb begin
    case (awaddr_reg & 6'h3c)
      OFS_CTL_A, OFS_CTL_B, OFS_CTL_C, OFS_ADDR_A, OFS_ADDR_B, OFS_ADDR_C,
      OFS_DATA, OFS_MASK, OFS_RANGE, OFS_STATUS: wr_hit = 1'b1;
      default:                                   wr_hit = 1'b0;
    endcase
  end

  // write response, held until taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  // configuration stores; unused control bits stay zero per channel [R11]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CHAN_N; i++) begin
        ctl_reg[i]  <= CTL_RST;
        addr_reg[i] <= ADDR_RST;
      end
      data_reg  <= DATA_RST;
      mask_reg  <= DATA_RST;
      range_reg <= RNG_RST;
    end else if (do_write) begin
      case (awaddr_reg & 6'h3c)
        OFS_CTL_A:  ctl_reg[0]  <= CTL_W'(strb_merge(AXI_DW'(ctl_reg[0]), wdata_reg, wstrb_reg))
                                    & CTL_MASK_A;
        OFS_CTL_B:  ctl_reg[1]  <= CTL_W'(strb_merge(AXI_DW'(ctl_reg[1]), wdata_reg, wstrb_reg))
                                    & CTL_MASK_B;
        OFS_CTL_C:  ctl_reg[2]  <= CTL_W'(strb_merge(AXI_DW'(ctl_reg[2]), wdata_reg, wstrb_reg))
                                    & CTL_MASK_C;
        OFS_ADDR_A: addr_reg[0] <= AW'(strb_merge(AXI_DW'(addr_reg[0]), wdata_reg, wstrb_reg));
        OFS_ADDR_B: addr_reg[1] <= AW'(strb_merge(AXI_DW'(addr_reg[1]), wdata_reg, wstrb_reg));
        OFS_ADDR_C: addr_reg[2] <= AW'(strb_merge(AXI_DW'(addr_reg[2]), wdata_reg, wstrb_reg));
        OFS_DATA:   data_reg    <= DW'(strb_merge(AXI_DW'(data_reg), wdata_reg, wstrb_reg));
        OFS_MASK:   mask_reg    <= DW'(strb_merge(AXI_DW'(mask_reg), wdata_reg, wstrb_reg));
        OFS_RANGE:  range_reg   <= RNG_W'(strb_merge(AXI_DW'(range_reg), wdata_reg, wstrb_reg));
        default:    range_reg   <= range_reg;
      endcase
    end
  end

  // read mux; narrow fields sit low, upper bits read zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr_i & 6'h3c)
      OFS_CTL_A:  rd_word = AXI_DW'(ctl_reg[0]);
      OFS_CTL_B:  rd_word = AXI_DW'(ctl_reg[1]);
      OFS_CTL_C:  rd_word = AXI_DW'(ctl_reg[2]);
      OFS_ADDR_A: rd_word = AXI_DW'(addr_reg[0]);
      OFS_ADDR_B: rd_word = AXI_DW'(addr_reg[1]);
      OFS_ADDR_C: rd_word = AXI_DW'(addr_reg[2]);
      OFS_DATA:   rd_word = AXI_DW'(data_reg);
      OFS_MASK:   rd_word = AXI_DW'(mask_reg);
      OFS_RANGE:  rd_word = AXI_DW'(range_reg);
      OFS_STATUS: rd_word = {count_reg, {(STAT_CNT_LO-CHAN_N){1'b0}}, last_reg};
      default:    rd_hit  = 1'b0;
    endcase
  end

  // read channel, one read in flight
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- comparators ----------------

  // no debug-mode cycle and no debug-logic access is watched [R2]
  assign bus_ok = bus_valid_i && !background_debug_mode_i && !background_debug_access_i;

  // range needs both compare enables; software sets or clears them together [R16]
  assign range_on  = range_reg[RNG_EN] && ctl_en[0] && ctl_en[1];
  // tagged ranges only resolve to words [R17]
  assign word_gran = range_on && ctl_tag[0];

  // three address channels, only the first has data [R1]
  for (genvar g = 0; g < CHAN_N; g++) begin : g_chan
    bcm_addr_cmp #(
      .AW       (AW),
      .HAS_SIZE (g < 2)
    ) u_cmp (
      .bus_addr_i  (bus_addr_i),
      .bus_rw_i    (bus_rw_i),
      .bus_word_i  (bus_word_i),
      .cmp_addr_i  (addr_reg[g]),
      .rwe_i       (ctl_reg[g][CTL_RWE]),
      .rw_i        (ctl_reg[g][CTL_RW]),
      .sze_i       (ctl_reg[g][CTL_SZE]),
      .sz_i        (ctl_reg[g][CTL_SZ]),
      .word_gran_i (word_gran && (g < 2)),
      .eq_o        (eq[g]),
      .ge_o        (ge[g]),
      .le_o        (le[g]),
      .dir_ok_o    (dir_ok[g]),
      .size_ok_o   (size_ok[g])
    );
  end

  bcm_data_cmp #(
    .DW (DW)
  ) u_data (
    .bus_data_i (bus_data_i),
    .cmp_data_i (data_reg),
    .cmp_mask_i (mask_reg),
    .ndb_i      (ctl_reg[0][CTL_NDB]),
    .data_ok_o  (data_ok)
  );

  // bus address is the aligned one, so straddling words judge by it [R18] [R19]
  assign range_cond = range_reg[RNG_OUT] ? (!ge[0] || !le[1]) // either bound alone [R19]
                                         : (ge[0] && le[1]);  // both in one cycle [R18]

  // forced matches fire on the bus cycle itself, fetches included [R6]
  always_comb begin
    forced_hit = '0;
    if (range_on) begin
      // pair follows the first channel; size and second-channel bits ignored [R15]
      forced_hit[0] = !ctl_tag[0] && range_cond && dir_ok[0] && data_ok;
    end else begin
      forced_hit[0] = ctl_en[0] && !ctl_tag[0] && eq[0] && dir_ok[0] && size_ok[0] && data_ok;
      forced_hit[1] = ctl_en[1] && !ctl_tag[1] && eq[1] && dir_ok[1] && size_ok[1];
    end
    // third channel: address and direction only [R11]
    forced_hit[2] = ctl_en[2] && !ctl_tag[2] && eq[2] && dir_ok[2];
  end

  // tags attach on fetch at the exact address, or on the range condition when range is on, qualifiers ignored [R5]
  always_comb begin
    attach = '0;
    if (bus_ok && bus_fetch_i) begin
      if (range_on) begin
        attach[0] = ctl_tag[0] && range_cond; // [R15]
      end else begin
        attach[0] = ctl_en[0] && ctl_tag[0] && eq[0];
        attach[1] = ctl_en[1] && ctl_tag[1] && eq[1];
      end
      attach[2] = ctl_en[2] && ctl_tag[2] && eq[2];
    end
  end

  // tag hits count only at execution and outside debug mode [R5] [R2]
  always_comb begin
    tagged_hit = '0;
    if (!background_debug_mode_i) begin
      if (range_on) begin
        tagged_hit[0] = tag_hit_i[0] && ctl_tag[0];
      end else begin
        tagged_hit[0] = tag_hit_i[0] && ctl_en[0] && ctl_tag[0];
        tagged_hit[1] = tag_hit_i[1] && ctl_en[1] && ctl_tag[1];
      end
      tagged_hit[2] = tag_hit_i[2] && ctl_en[2] && ctl_tag[2];
    end
  end

  // no memory of earlier matches: each cycle stands alone [R8]
  assign raw_match = ({CHAN_N{bus_ok}} & forced_hit) | tagged_hit;

  // final-state channel wins, then lowest number; rest dropped [R21]
  assign winner = (|(raw_match & final_state_chan_i)) ? lowest_one(raw_match & final_state_chan_i)
                                                      : lowest_one(raw_match);

  // registered one-cycle pulses; range shares output zero [R22] [R9]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_o      <= '0;
      breakpoint_o <= '0;
      tag_attach_o <= '0;
    end else begin
      match_o      <= winner;                         // [R9] [R22]
      breakpoint_o <= winner & ctl_brk;               // [R15]
      tag_attach_o <= attach;
    end
  end

  // status: last winner and a wrapping count of matches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_reg  <= '0;
      count_reg <= '0;
    end else if (|winner) begin
      last_reg  <= winner;
      count_reg <= count_reg + CNT_W'(1);
    end
  end

endmodule : bcm_top

// ==== logic/bcm_pkg.sv ====
package bcm_pkg;

  // widths of the watched buses and of the register bus
  localparam int CMP_ADDR_W = 18;
  localparam int CMP_DATA_W = 16;
  localparam int CHAN_N     = 3;
  localparam int AXI_AW     = 6;
  localparam int AXI_DW     = 32;
  localparam int REG_IDX_W  = 4;
  localparam int REG_IDX_LO = 2;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CTL_A  = 6'h00;
  localparam logic [AXI_AW-1:0] OFS_CTL_B  = 6'h04;
  localparam logic [AXI_AW-1:0] OFS_CTL_C  = 6'h08;
  localparam logic [AXI_AW-1:0] OFS_ADDR_A = 6'h0c;
  localparam logic [AXI_AW-1:0] OFS_ADDR_B = 6'h10;
  localparam logic [AXI_AW-1:0] OFS_ADDR_C = 6'h14;
  localparam logic [AXI_AW-1:0] OFS_DATA   = 6'h18;
  localparam logic [AXI_AW-1:0] OFS_MASK   = 6'h1c;
  localparam logic [AXI_AW-1:0] OFS_RANGE  = 6'h20;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 6'h24;

  // channel control field positions
  localparam int CTL_W   = 8;
  localparam int CTL_EN  = 0;
  localparam int CTL_TAG = 1;
  localparam int CTL_BRK = 2;
  localparam int CTL_RWE = 3;
  localparam int CTL_RW  = 4;
  localparam int CTL_SZE = 5;
  localparam int CTL_SZ  = 6;
  localparam int CTL_NDB = 7;

  // writable control bits per channel; the third has no size or data fields
  localparam logic [CTL_W-1:0] CTL_MASK_A = 8'hff;
  localparam logic [CTL_W-1:0] CTL_MASK_B = 8'h7f;
  localparam logic [CTL_W-1:0] CTL_MASK_C = 8'h1f;

  // range control field positions
  localparam int RNG_W   = 2;
  localparam int RNG_EN  = 0;
  localparam int RNG_OUT = 1;

  // status layout: last winning match, then match count
  localparam int STAT_CNT_LO = 16;
  localparam int CNT_W       = 16;

  // reset values
  localparam logic [CTL_W-1:0]      CTL_RST  = 8'h00;
  localparam logic [CMP_ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [CMP_DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [RNG_W-1:0]      RNG_RST  = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : bcm_pkg

// ==== logic/bcm_addr_cmp.sv ====
// address and access-type comparison for one channel
module bcm_addr_cmp
  import bcm_pkg::*;
#(
  parameter int  AW       = CMP_ADDR_W,
  parameter bit  HAS_SIZE = 1'b1
) (
  // observed access
  input  wire logic [AW-1:0] bus_addr_i,
  input  wire logic          bus_rw_i,
  input  wire logic          bus_word_i,
  // channel settings
  input  wire logic [AW-1:0] cmp_addr_i,
  input  wire logic          rwe_i,
  input  wire logic          rw_i,
  input  wire logic          sze_i,
  input  wire logic          sz_i,
  input  wire logic          word_gran_i,
  // results
  output logic               eq_o,
  output logic               ge_o,
  output logic               le_o,
  output logic               dir_ok_o,
  output logic               size_ok_o
);

  logic [AW-1:0] gran_mask;
  logic [AW-1:0] a_bus;
  logic [AW-1:0] a_cmp;

  // tagged ranges resolve only to words, so bit 0 drops out
  assign gran_mask = word_gran_i ? {{(AW-1){1'b1}}, 1'b0} : {AW{1'b1}};
  assign a_bus     = bus_addr_i & gran_mask;
  assign a_cmp     = cmp_addr_i & gran_mask;

  // exact address only: a word at n-1 never hits n [R10]
  assign eq_o = (a_bus == a_cmp);
  assign ge_o = (a_bus >= a_cmp);
  assign le_o = (a_bus <= a_cmp);

  // direction: 0 selects writes, 1 selects reads [R3]
  assign dir_ok_o = !rwe_i || (rw_i == bus_rw_i);

  // size: 0 selects word, 1 selects byte [R4]
  assign size_ok_o = !HAS_SIZE || !sze_i || (sz_i == !bus_word_i);

endmodule : bcm_addr_cmp

// ==== logic/bcm_data_cmp.sv ====
// masked data comparison for the first channel
module bcm_data_cmp
  import bcm_pkg::*;
#(
  parameter int DW = CMP_DATA_W
) (
  input  wire logic [DW-1:0] bus_data_i,
  input  wire logic [DW-1:0] cmp_data_i,
  input  wire logic [DW-1:0] cmp_mask_i,
  input  wire logic          ndb_i,
  output logic               data_ok_o
);

  logic [DW-1:0] diff_bits;

  // high byte lane carries the lower address, so it meets the high stored byte [R12]
  assign diff_bits = (bus_data_i ^ cmp_data_i) & cmp_mask_i;

  // equality passes on a zero mask, difference never does [R13] [R14]
  assign data_ok_o = ndb_i ? (|diff_bits) : (diff_bits == '0);

endmodule : bcm_data_cmp

// ==== sim/bcm_sva.sv ====
module bcm_sva
  import bcm_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  // causes
  input wire logic              bus_valid_i,
  input wire logic              bus_fetch_i,
  input wire logic              background_debug_mode_i,
  input wire logic              background_debug_access_i,
  input wire logic [CHAN_N-1:0] tag_hit_i,
  // results
  input wire logic [CHAN_N-1:0] tag_attach_o,
  input wire logic [CHAN_N-1:0] match_o,
  input wire logic [CHAN_N-1:0] breakpoint_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // nothing on the bus and no tag hit
  sequence s_quiet; !bus_valid_i && tag_hit_i == '0; endsequence
  sequence s_hit; tag_hit_i != '0 && !background_debug_mode_i; endsequence
  property p_onehot; $onehot0(match_o); endproperty
  property p_mode; background_debug_mode_i |=> match_o == '0; endproperty
  property p_mode_tag; background_debug_mode_i |=> tag_attach_o == '0; endproperty
  property p_access; background_debug_access_i && tag_hit_i == '0 |=> match_o == '0; endproperty
  property p_quiet; s_quiet |=> match_o == '0 && tag_attach_o == '0; endproperty
  property p_hit; s_hit |=> match_o != '0; endproperty
  property p_attach; tag_attach_o != '0 |-> $past(bus_valid_i && bus_fetch_i); endproperty
  property p_brk; (breakpoint_o & ~match_o) == '0; endproperty
  a_onehot: assert property (p_onehot)
    else $error("several matches at once");
  a_mode: assert property (p_mode)
    else $error("match in debug mode");
  a_mode_tag: assert property (p_mode_tag)
    else $error("tag attached in debug mode");
  a_access: assert property (p_access)
    else $error("match on debug access");
  a_quiet: assert property (p_quiet)
    else $error("output without a cause");
  a_hit: assert property (p_hit)
    else $error("tag hit gave no match");
  a_attach: assert property (p_attach)
    else $error("tag attached without a fetch");
  a_brk: assert property (p_brk)
    else $error("breakpoint without match");
endmodule : bcm_sva

bind bcm_top bcm_sva i_bcm_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_valid_i(bus_valid_i), .bus_fetch_i(bus_fetch_i),
  .background_debug_mode_i(background_debug_mode_i), .background_debug_access_i(background_debug_access_i),
  .tag_hit_i(tag_hit_i), .tag_attach_o(tag_attach_o), .match_o(match_o), .breakpoint_o(breakpoint_o)
);

// ==== sim/bcm_cpu_model.sv ====
module bcm_cpu_model
  import bcm_pkg::*;
(
  // clock and tag timing
  input  wire logic [3:0]        hit_delay_i,
  input  wire logic              clk_i,
  input  wire logic [CHAN_N-1:0] tag_attach_i,
  output logic [CHAN_N-1:0]      tag_hit_o,
  // bus cycle
  output logic                   bus_valid_o,
  output logic [CMP_ADDR_W-1:0]  bus_addr_o,
  output logic [CMP_DATA_W-1:0]  bus_data_o,
  output logic                   bus_rw_o,
  output logic                   bus_word_o,
  output logic                   bus_fetch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]        cnt_reg = '0;
  logic [CHAN_N-1:0] held_reg = '0;
  initial begin
    {tag_hit_o, bus_valid_o, bus_addr_o, bus_data_o, bus_rw_o, bus_word_o, bus_fetch_o} = '0;
  end
  // one bus cycle, held up to the sampling edge
  task cycle(input logic [CMP_ADDR_W-1:0] a, input logic [CMP_DATA_W-1:0] d, input logic r, w, f);
    bus_valid_o <= 1'b1;
    bus_addr_o  <= a;
    bus_data_o  <= d;
    bus_rw_o    <= r;
    bus_word_o  <= w;
    bus_fetch_o <= f;
    @(posedge clk_i);
  endtask : cycle
  // released lines flip so a stale value cannot fake a match
  task idle;
    bus_valid_o <= 1'b0;
    bus_fetch_o <= 1'b0;
    bus_addr_o  <= ~bus_addr_o;
    bus_data_o  <= ~bus_data_o;
    @(posedge clk_i);
  endtask : idle
  // tagged opcode executes later; a newer tag replaces an older one
  always @(posedge clk_i) begin
    if (tag_attach_i != '0) begin
      cnt_reg  <= hit_delay_i;
      held_reg <= tag_attach_i;
    end
    else if (cnt_reg != '0) cnt_reg <= cnt_reg - 4'h1;
    tag_hit_o <= (cnt_reg == 4'h1 && tag_attach_i == '0) ? held_reg : '0;
  end
endmodule : bcm_cpu_model

// ==== sim/bcm_top_test.sv ====
module bcm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bcm_pkg::*;
  logic        clk_i = 0, rst_n_i = 0, awv = 0, wv = 0, arv = 0, rdy = 0, background_debug_mode = 0, bda = 0;
  logic        awr, wrd, bv, arr, rv, vld, rw, wd, fe;
  logic [5:0]  awa = '0, ara = '0;
  logic [31:0] wdat = '0, rdat;
  logic [1:0]  bresp, rresp;
  logic [2:0]  fs = '0, hit, att, m, bp;
  logic [3:0]  dly = 4'h1;
  logic [17:0] ba;
  logic [15:0] bd;
  int          num_errors = 0, check_count = 0, seed = 32'h9bbd;
  int          cfg[9] = '{default: 0}, last = 0, cnt = 0, em = 0, eb = 0, ea = 0;

  bcm_top i_bcm_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wdat), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(rdy), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rdy),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .bus_valid_i(vld), .bus_addr_i(ba), .bus_data_i(bd),
    .bus_rw_i(rw), .bus_word_i(wd), .bus_fetch_i(fe), .background_debug_mode_i(background_debug_mode),
    .background_debug_access_i(bda), .tag_attach_o(att), .tag_hit_i(hit), .final_state_chan_i(fs),
    .match_o(m), .breakpoint_o(bp)
  );
  bcm_cpu_model i_bcm_cpu_model (
    .clk_i(clk_i), .hit_delay_i(dly), .tag_attach_i(att), .tag_hit_o(hit), .bus_valid_o(vld),
    .bus_addr_o(ba), .bus_data_o(bd), .bus_rw_o(rw), .bus_word_o(wd), .bus_fetch_o(fe)
  );

  // 125 mhz clock
  initial forever #4 clk_i = ~clk_i;

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awa <= a;
    wdat <= d;
    awv <= 1;
    wv <= 1;
    while (pa | pw) begin
      @(posedge clk_i);
      if (pa & awr) awv <= 0;
      if (pw & wrd) wv <= 0;
      pa = pa & !awr;
      pw = pw & !wrd;
    end
    do @(posedge clk_i); while (bv !== 1'b1);
    chk(bresp, r);
  endtask : wr

  task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a;
    arv <= 1;
    do @(posedge clk_i); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk_i); while (rv !== 1'b1);
    chk(rresp, r);
    if (r == RESP_OKAY) chk(rdat, e);
  endtask : rd

  // reference: judge last cycle's outputs, then predict from this cycle
  always @(posedge clk_i) begin
    int f, t, ok, g, a, in_r;
    if (rst_n_i) begin
      chk(m, em);
      chk(bp, eb);
      chk(att, ea);
      cnt += (em != 0);
      if (em != 0) last = em;
      ok = cfg[0][CTL_NDB] ? ((bd ^ cfg[6]) & cfg[7]) != 0 : ((bd ^ cfg[6]) & cfg[7]) == 0;
      f = 0;
      t = 0;
      for (int i = 0; i < 3; i++) begin
        if (cfg[i][CTL_TAG]) t |= (fe && ba == cfg[i+3] && cfg[i][CTL_EN]) << i;
        else f |= (ba == cfg[i+3] && cfg[i][CTL_EN] && (!cfg[i][CTL_RWE] || rw == cfg[i][CTL_RW])
                   && (i == 2 || !cfg[i][CTL_SZE] || wd != cfg[i][CTL_SZ]) && (i > 0 || ok)) << i;
      end
      if (cfg[8][RNG_EN] && cfg[0][CTL_EN] && cfg[1][CTL_EN]) begin
        g = cfg[0][CTL_TAG];
        a = ba >> g;
        in_r = cfg[8][RNG_OUT] ? (a < cfg[3] >> g || a > cfg[4] >> g) : (a >= cfg[3] >> g && a <= cfg[4] >> g);
        f &= 4;
        t &= 4;
        if (g) t |= in_r && fe;
        else f |= in_r && ok && (!cfg[0][CTL_RWE] || rw == cfg[0][CTL_RW]);
      end
      if (!vld || background_debug_mode || bda) f = 0;
      if (!vld || background_debug_mode || bda) t = 0;
      f |= background_debug_mode ? 0 : hit;
      if ((f & fs) != 0) f &= fs;
      em = f & -f;
      eb = em & {cfg[2][CTL_BRK], cfg[1][CTL_BRK], cfg[0][CTL_BRK]};
      ea = t;
    end
  end

  // random setup, readback, then random traffic
  task phase;
    int v[9];
    int r;
    for (int i = 0; i < 9; i++) v[i] = $random(seed);
    for (int i = 0; i < 3; i++) begin
      v[i][0] = v[i][0] | v[i][9];
      if (!v[i][1] && v[i][10]) v[i+3][0] = 1'b0;
    end
    if (v[7][20]) v[7] = 0;
    if (v[8][0]) v[1][0] = v[0][0];
    if (v[8][1] && !v[0][1]) v[4] = 32'h3ffff;
    for (int i = 0; i < 9; i++) begin
      cfg[i] = v[i] & (i == 0 ? CTL_MASK_A : i == 1 ? CTL_MASK_B : i == 2 ? CTL_MASK_C :
                       i < 6 ? 32'h3ffff : i < 8 ? 32'hffff : 32'h3);
      wr(6'(i * 4), v[i], RESP_OKAY);
      rd(6'(i * 4), cfg[i], RESP_OKAY);
    end
    dly <= 4'h1 + 4'(v[8] >> 8 & 7);
    repeat (60) begin
      r = $random(seed);
      background_debug_mode <= r[5] & r[6];
      bda <= r[7] & r[8] & !r[9];
      fs <= r[13:11];
      if (r[9] | r[10]) i_bcm_cpu_model.cycle(r[4] ? 18'(r >> 14) : 18'(cfg[3 + r[1:0] % 3] + r[3:2] - 1),
                                              r[15] ? 16'(cfg[6]) : r[31:16], r[9], r[14], r[9] & r[12]);
      else i_bcm_cpu_model.idle();
    end
    background_debug_mode <= 0;
    bda <= 0;
    repeat (12) i_bcm_cpu_model.idle();
    wr(OFS_STATUS, '1, RESP_OKAY);
    rd(OFS_STATUS, {16'(cnt), 13'h0, 3'(last)}, RESP_OKAY);
  endtask : phase

  task conclude;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1;
    rdy <= 1;
    for (int i = 0; i < 10; i++) rd(6'(i * 4), 0, RESP_OKAY);
    wr(6'h28, '1, RESP_SLVERR);
    rd(6'h28, 0, RESP_SLVERR);
    repeat (40) phase();
    conclude();
  end

  // watchdog well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : bcm_top_test
